/* dv/i2cx_ctrl_model.sv */
`timescale 1ns/1ps
// Bus controller; SCL stands high between frames, a released SDA reads as the pull-up
module i2cx_ctrl_model (
   output logic      scl_o,
   output logic      sda_o,
   input  wire logic sda_i
);
   localparam realtime Q = 31.25;
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic start;
      #Q sda_o = 1'b1;
      #Q scl_o = 1'b1;
      #(2*Q) sda_o = 1'b0;
      #(2*Q) scl_o = 1'b0;
   endtask : start
   task automatic stop;
      #Q sda_o = 1'b0;
      #Q scl_o = 1'b1;
      #(2*Q) sda_o = 1'b1;
      #(2*Q);
   endtask : stop
   // Data moves only while SCL is low and is sampled mid high phase
   task automatic clock_bit(input logic b, output logic s);
      #Q sda_o = b;
      #Q scl_o = 1'b1;
      #Q s = sda_i;
      #Q scl_o = 1'b0;
   endtask : clock_bit
   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
      clock_bit(1'b1, s);
      ack = ~s;
   endtask : put_byte
   // Ack asks for one more byte, not-ack ends the read
   task automatic get_byte(input logic more, output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         clock_bit(1'b1, s);
         d[i] = s;
      end
      clock_bit(~more, s);
   endtask : get_byte
endmodule : i2cx_ctrl_model

/* dv/test_i2cx_top.sv */
`timescale 1ns/1ps
module test_i2cx_top
   import i2cx_pkg::*;
;
   localparam logic [23:0] ONES_MAP = 24'h0F0FCC;
   // Run needs about 61000 cycles
   localparam int          LIMIT    = 90000;
   logic        clk = 1'b0;
   logic        resetn = 1'b0;
   logic        strap = 1'b0;
   logic        rdy = 1'b1;
   logic [15:0] pins = 16'hA5C3;
   logic [15:0] flags = 16'h0000;
   logic        scl, m_sda, sda_o, sda_oe, sda_w, wv, srst;
   logic [15:0] wd;
   logic [7:0]  pat [24];
   logic [15:0] got_q [$];
   int          bad_count = 0;
   int          checks_done = 0;
   int          cyc = 0;
   int          pulses = 0;
   // Open-drain wire with pull-up: any party pulling low wins
   assign sda_w = m_sda & ~(sda_oe & ~sda_o);
   always #5 clk = ~clk;
   i2cx_top #(.FIFO_DEPTH(16)) dut (
      .clk_i(clk), .resetn_i(resetn), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o),
      .sda_oe_o(sda_oe), .addr_strap_i(strap), .pin_level_i(pins), .event_flags_i(flags),
      .wr_valid_o(wv), .wr_data_o(wd), .wr_ready_i(rdy), .soft_reset_o(srst));
   i2cx_ctrl_model host (.scl_o(scl), .sda_o(m_sda), .sda_i(sda_w));
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (wv === 1'b1 && rdy) got_q.push_back(wd);
      if (srst === 1'b1) pulses++;
      if (cyc == LIMIT) begin
         bad_count++;
         conclude();
      end
   end
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : conclude
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic send(input logic [7:0] b, input logic exp);
      logic a;
      host.put_byte(b, a);
      check($sformatf("ack of %h", b), 16'(exp), 16'(a));
   endtask : send
   function automatic logic [7:0] addr(input logic rd);
      return {DEV_ADDR_BASE[6:1], strap, rd};
   endfunction : addr
   task automatic write_reg(input logic [7:0] c, input logic [7:0] d, input bit data);
      host.start();
      send(addr(1'b0), 1'b1);
      send(c, 1'b1);
      if (data) send(d, 1'b1);
      host.stop();
   endtask : write_reg
   // Two bytes in one read: the pointer must not move
   task automatic read_reg(input logic [7:0] exp);
      logic [7:0] d;
      host.start();
      send(addr(1'b1), 1'b1);
      host.get_byte(1'b1, d);
      check("read byte", 16'(exp), 16'(d));
      host.get_byte(1'b0, d);
      check("repeat byte", 16'(exp), 16'(d));
      host.stop();
   endtask : read_reg
   function automatic logic [7:0] ofs(input int i);
      return (i < 8) ? 8'(i) : 8'(8'h38 + i);
   endfunction : ofs
   function automatic logic [7:0] dflt(input int i);
      if (i < 2) return pins[8*i +: 8];
      if (i == 20 || i == 21) return flags[8*(i-20) +: 8];
      return ONES_MAP[i] ? RST_ONES : RST_ZEROS;
   endfunction : dflt
   function automatic bit writable(input int i);
      return !(i < 2 || (i > 19 && i < 23));
   endfunction : writable
   task automatic check_all(input bit written);
      for (int i = 0; i < 24; i++) begin
         write_reg(ofs(i), 8'h00, 1'b0);
         read_reg((written && writable(i)) ? pat[i] : dflt(i));
      end
   endtask : check_all
   initial begin
      for (int i = 0; i < 24; i++) pat[i] = 8'(i * 11) ^ 8'hA5;
      repeat (6) @(posedge clk);
      #1 resetn = 1'b1;
      repeat (5) @(posedge clk);
      read_reg(pins[7:0]);
      check_all(1'b0);
      $display("test defaults done");
      for (int i = 0; i < 24; i++) write_reg(ofs(i), pat[i], 1'b1);
      @(posedge clk) #1 pins = 16'h3C96;
      flags = 16'h5AE1;
      check_all(1'b1);
      check("pushed words", 16'd19, 16'(got_q.size()));
      foreach (pat[i])
         if (writable(i)) check("pushed word", {ofs(i), pat[i]}, got_q.pop_front());
      $display("test write readback done");
      @(posedge clk) #1 strap = 1'b1;
      read_reg(pat[23]);
      host.start();
      send(8'h40, 1'b0);
      host.start();
      send(8'h44, 1'b0);
      host.stop();
      @(posedge clk) #1 strap = 1'b0;
      $display("test address done");
      host.start();
      send(GC_ADDR_BYTE, 1'b1);
      send(8'h07, 1'b0);
      host.stop();
      host.start();
      send(GC_ADDR_BYTE, 1'b1);
      send(SWRST_CODE, 1'b1);
      send(SWRST_CODE, 1'b0);
      host.stop();
      host.start();
      send(GC_ADDR_BYTE, 1'b1);
      send(SWRST_CODE, 1'b1);
      host.start();
      send(8'h01, 1'b0);
      host.stop();
      read_reg(pat[23]);
      host.start();
      send(GC_ADDR_BYTE, 1'b1);
      send(SWRST_CODE, 1'b1);
      host.stop();
      repeat (4) @(posedge clk);
      check("reset pulses", 16'd1, 16'(pulses));
      read_reg(pins[7:0]);
      check_all(1'b0);
      $display("test software reset done");
      got_q.delete();
      @(posedge clk) #1 rdy = 1'b0;
      host.start();
      send(addr(1'b0), 1'b1);
      send(OFS_INVERT_LO, 1'b1);
      for (int k = 0; k < 17; k++) send(8'(k), 1'b1);
      send(8'hEE, 1'b0);
      host.stop();
      @(posedge clk) #1 rdy = 1'b1;
      for (int n = 0; n < 100 && got_q.size() < 17; n++) @(posedge clk);
      check("queued words", 16'd17, 16'(got_q.size()));
      for (int k = 0; k < 17; k++) check("queued word", {OFS_INVERT_LO, 8'(k)}, got_q.pop_front());
      read_reg(8'h10);
      $display("test fifo done");
      conclude();
   end
endmodule : test_i2cx_top

/* pkg/i2cx_pkg.sv */
package i2cx_pkg;
   localparam logic [6:0] DEV_ADDR_BASE = 7'h20;
   localparam logic [7:0] GC_ADDR_BYTE  = 8'h00;
   localparam logic [7:0] SWRST_CODE    = 8'h06;
   localparam logic [7:0] PTR_RESET     = 8'h00;
   localparam logic [3:0] BYTE_BITS     = 4'h8;
   localparam int         EXT_BIT       = 6;
   localparam logic [7:0] RST_ONES      = 8'hFF;
   localparam logic [7:0] RST_ZEROS     = 8'h00;

   localparam logic [7:0] OFS_PIN_LEVEL_LO   = 8'h00;
   localparam logic [7:0] OFS_PIN_LEVEL_HI   = 8'h01;
   localparam logic [7:0] OFS_DRIVE_VALUE_LO = 8'h02;
   localparam logic [7:0] OFS_DRIVE_VALUE_HI = 8'h03;
   localparam logic [7:0] OFS_INVERT_LO      = 8'h04;
   localparam logic [7:0] OFS_INVERT_HI      = 8'h05;
   localparam logic [7:0] OFS_DIRECTION_LO   = 8'h06;
   localparam logic [7:0] OFS_DIRECTION_HI   = 8'h07;
   localparam logic [7:0] OFS_STRENGTH_A     = 8'h40;
   localparam logic [7:0] OFS_STRENGTH_B     = 8'h41;
   localparam logic [7:0] OFS_STRENGTH_C     = 8'h42;
   localparam logic [7:0] OFS_STRENGTH_D     = 8'h43;
   localparam logic [7:0] OFS_HOLD_EN_LO     = 8'h44;
   localparam logic [7:0] OFS_HOLD_EN_HI     = 8'h45;
   localparam logic [7:0] OFS_BIAS_EN_LO     = 8'h46;
   localparam logic [7:0] OFS_BIAS_EN_HI     = 8'h47;
   localparam logic [7:0] OFS_BIAS_SEL_LO    = 8'h48;
   localparam logic [7:0] OFS_BIAS_SEL_HI    = 8'h49;
   localparam logic [7:0] OFS_EVENT_MASK_LO  = 8'h4A;
   localparam logic [7:0] OFS_EVENT_MASK_HI  = 8'h4B;
   localparam logic [7:0] OFS_EVENT_FLAGS_LO = 8'h4C;
   localparam logic [7:0] OFS_EVENT_FLAGS_HI = 8'h4D;
   localparam logic [7:0] OFS_STAGE_STYLE    = 8'h4F;

   typedef enum logic [2:0] {
      ST_IDLE = 3'h0, ST_RX = 3'h1, ST_ACK = 3'h3, ST_TX = 3'h2, ST_MACK = 3'h6
   } i2cx_state_t;

   typedef enum logic [2:0] {
      PH_ADDR = 3'h0, PH_CMD = 3'h1, PH_DATA = 3'h3, PH_READ = 3'h2,
      PH_GC = 3'h6, PH_GC_ARM = 3'h7
   } i2cx_phase_t;

   // Bit 6 picks the extended group, low nibble the register in it
   function automatic logic [4:0] rf_index(input logic [7:0] ptr);
      return {ptr[EXT_BIT], ptr[3:0]};
   endfunction : rf_index

   function automatic logic rf_readonly(input logic [7:0] ptr);
      return ptr == OFS_PIN_LEVEL_LO || ptr == OFS_PIN_LEVEL_HI ||
             ptr == OFS_EVENT_FLAGS_LO || ptr == OFS_EVENT_FLAGS_HI;
   endfunction : rf_readonly

   function automatic logic rf_writable(input logic [7:0] ptr);
      logic ok;
      ok = (ptr >= OFS_DRIVE_VALUE_LO && ptr <= OFS_DIRECTION_HI) ||
           (ptr >= OFS_STRENGTH_A && ptr <= OFS_EVENT_MASK_HI) ||
           ptr == OFS_STAGE_STYLE;
      return ok;
   endfunction : rf_writable

   function automatic logic [7:0] rf_reset(input logic [7:0] ptr);
      logic [7:0] v;
      v = RST_ZEROS;
      case (ptr)
         OFS_DRIVE_VALUE_LO, OFS_DRIVE_VALUE_HI, OFS_DIRECTION_LO, OFS_DIRECTION_HI,
         OFS_STRENGTH_A, OFS_STRENGTH_B, OFS_STRENGTH_C, OFS_STRENGTH_D,
         OFS_BIAS_SEL_LO, OFS_BIAS_SEL_HI, OFS_EVENT_MASK_LO, OFS_EVENT_MASK_HI: v = RST_ONES;
         default: v = RST_ZEROS;
      endcase
      return v;
   endfunction : rf_reset
endpackage : i2cx_pkg

/* pkg/i2cx_rf_if.sv */
`timescale 1ns/1ps
interface i2cx_rf_if;
   logic       we;
   logic [7:0] waddr;
   logic [7:0] wdata;
   logic [7:0] raddr;
   logic [7:0] rdata;
   logic       clr;
   modport ctrl  (output we, waddr, wdata, raddr, clr, input rdata);
   modport store (input we, waddr, wdata, raddr, clr, output rdata);
endinterface : i2cx_rf_if

/* src/i2cx_fifo.sv */
`timescale 1ns/1ps
module i2cx_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             clk_i,
   input  wire logic             resetn_i,
   input  wire logic             clr_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0]    wptr_reg;
   logic [AW-1:0]    rptr_reg;
   logic [AW:0]      count_reg;
   logic             push;
   logic             pop;

   // Output stage is a register so the drain side sees flop outputs
   assign in_ready_o = count_reg != (AW+1)'(DEPTH);
   assign push = in_valid_i && in_ready_o;
   assign pop = count_reg != '0 && (!out_valid_o || out_ready_i);

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_reg[wptr_reg] <= in_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
      end else if (clr_i) begin
         wptr_reg <= '0;
         rptr_reg <= '0;
         count_reg <= '0;
      end else begin
         wptr_reg <= push ? AW'(wptr_reg + 1'b1) : wptr_reg;
         rptr_reg <= pop ? AW'(rptr_reg + 1'b1) : rptr_reg;
         count_reg <= (AW+1)'(count_reg + push - pop);
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         out_valid_o <= 1'b0;
         out_data_o <= '0;
      end else if (clr_i) begin
         out_valid_o <= 1'b0;
      end else if (pop) begin
         out_valid_o <= 1'b1;
         out_data_o <= mem_reg[rptr_reg];
      end else if (out_ready_i) begin
         out_valid_o <= 1'b0;
      end
   end
endmodule : i2cx_fifo

/* src/i2cx_regfile.sv */
`timescale 1ns/1ps
module i2cx_regfile
   import i2cx_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   i2cx_rf_if.store         rf,
   input  wire logic [15:0] pin_level_i,
   input  wire logic [15:0] event_flags_i
);
   logic [7:0] mem_reg [32];

   for (genvar i = 0; i < 32; i++) begin : g_cell
      localparam logic [4:0] IDX = 5'(i);
      localparam logic [7:0] CELL_PTR = {1'b0, IDX[4], 2'b00, IDX[3:0]};
      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            mem_reg[i] <= rf_reset(CELL_PTR); // [R14] [R17] [R18] [R19] [R20] [R22]
         end else if (rf.clr) begin
            mem_reg[i] <= rf_reset(CELL_PTR); // [R24]
         end else if (rf.we && rf_writable(rf.waddr) && rf_index(rf.waddr) == IDX) begin
            mem_reg[i] <= rf.wdata; // [R23] [R25]
         end
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rf.rdata <= RST_ZEROS;
      end else begin
         case (rf.raddr)
            OFS_PIN_LEVEL_LO:   rf.rdata <= pin_level_i[7:0]; // [R16] [R23]
            OFS_PIN_LEVEL_HI:   rf.rdata <= pin_level_i[15:8];
            OFS_EVENT_FLAGS_LO: rf.rdata <= event_flags_i[7:0]; // [R21]
            OFS_EVENT_FLAGS_HI: rf.rdata <= event_flags_i[15:8];
            default: rf.rdata <= rf_writable(rf.raddr) ? mem_reg[rf_index(rf.raddr)]
                                                       : RST_ZEROS; // [R15] [R25]
         endcase
      end
   end

   AST_UNMAPPED_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i) // [R25]
      !rf_writable(rf.raddr) && !rf_readonly(rf.raddr) |=> rf.rdata == RST_ZEROS)
      else $error("unmapped command did not read zero");
endmodule : i2cx_regfile

/* src/i2cx_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// [R01] Start is SDA falling with SCL high; stop is SDA rising with SCL high.
// [R02] Address byte arrives MSB first with direction bit last.
// [R03] On own address, SDA is held low through the acknowledge clock high.
// [R04] SDA is data only at SCL high; changes there mean start or stop.
// [R05] Each byte is eight bit clocks plus one acknowledge clock.
// [R06] The sender releases SDA before the acknowledge clock.
// [R07] Every byte written to the device is acknowledged; the code NACKs data for a writable register while the FIFO is full.
// [R08] The controller acknowledges read bytes it wants continued.
// [R09] On a read not-acknowledge the device releases SDA for the stop.
// [R10] Device answers 0x20 with strap low, 0x21 with strap high, else ignores.
// [R11] Address LSB 1 means read, 0 means write.
// [R12] First write byte after the address is the command, kept as pointer.
// [R13] The pointer persists; reads repeat the same register until rewritten.
// [R14] Pointer clears to zero on power-up, hardware and software reset.
// [R15] Command bit 6 selects the extended register group.
// [R16] Commands 00-07: pin level, drive value, invert, direction pairs.
// [R17] Commands 40-43: drive strength, reset all ones.
// [R18] Commands 44-45: hold enable, reset zero.
// [R19] Commands 46-47 bias enable reset zero; 48-49 bias select reset ones.
// [R20] Commands 4A-4B: event mask, reset all ones.
// [R21] Commands 4C-4D: read-only event flags, reset zero.
// [R22] Command 4F: output stage style, reset zero.
// [R23] Writes to pin level registers are ignored; reads give live pin levels.
// [R24] General call, byte 0x06 then stop resets all; anything else cancels.
// [R25] Unknown commands ignore writes and read as zero.
module i2cx_top
   import i2cx_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   input  wire logic        scl_i,
   input  wire logic        sda_i,
   output logic             sda_o,
   output logic             sda_oe_o,
   input  wire logic        addr_strap_i,
   input  wire logic [15:0] pin_level_i,
   input  wire logic [15:0] event_flags_i,
   output logic             wr_valid_o,
   output logic [15:0]      wr_data_o,
   input  wire logic        wr_ready_i,
   output logic             soft_reset_o
);
   logic [1:0]  scl_sync_reg;
   logic [1:0]  sda_sync_reg;
   logic [1:0]  strap_sync_reg;
   logic [15:0] pin_meta_reg;
   logic [15:0] pin_sync_reg;
   logic        scl_prev_reg;
   logic        sda_prev_reg;
   logic        strap_reg;
   i2cx_state_t state_reg;
   i2cx_phase_t phase_reg;
   i2cx_phase_t phase_next;
   logic [3:0]  bit_cnt_reg;
   logic [7:0]  shift_reg;
   logic [7:0]  ptr_reg;
   logic        mack_reg;
   logic        scl_s;
   logic        sda_s;
   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic        byte_end;
   logic        ack_now;
   logic        armed;
   logic        wr_take;
   logic        fifo_in_ready;

   i2cx_rf_if rf ();

   // Pins are async to clk_i: two flops before any logic looks at them
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
         strap_sync_reg <= 2'h0;
         pin_meta_reg <= 16'h0000;
         pin_sync_reg <= 16'h0000;
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], scl_i};
         sda_sync_reg <= {sda_sync_reg[0], sda_i};
         strap_sync_reg <= {strap_sync_reg[0], addr_strap_i};
         pin_meta_reg <= pin_level_i;
         pin_sync_reg <= pin_meta_reg;
         scl_prev_reg <= scl_sync_reg[1];
         sda_prev_reg <= sda_sync_reg[1];
      end
   end

   assign scl_s = scl_sync_reg[1];
   assign sda_s = sda_sync_reg[1];
   assign scl_rise = scl_s && !scl_prev_reg;
   assign scl_fall = !scl_s && scl_prev_reg;
   assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s; // [R01] [R04]
   assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s; // [R01] [R04]
   assign byte_end = scl_fall && state_reg == ST_RX && bit_cnt_reg == BYTE_BITS; // [R05]
   // The SCL rise just before a stop has already counted one bit, so allow one
   assign armed = phase_reg == PH_GC_ARM && state_reg == ST_RX && bit_cnt_reg <= 4'h1;

   // Strap is frozen per transfer so a moving pin cannot split an address
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         strap_reg <= 1'b0;
      end else if (start_det) begin
         strap_reg <= strap_sync_reg[1];
      end
   end

   // Verdict on a completed byte
   always_comb begin
      ack_now = 1'b0;
      phase_next = phase_reg;
      case (phase_reg)
         PH_ADDR: begin
            if (shift_reg[7:1] == {DEV_ADDR_BASE[6:1], strap_reg}) begin // [R10]
               ack_now = 1'b1;
               phase_next = shift_reg[0] ? PH_READ : PH_CMD; // [R11] [R12]
            end else if (shift_reg == GC_ADDR_BYTE) begin // [R24]
               ack_now = 1'b1;
               phase_next = PH_GC;
            end
         end
         PH_CMD: begin
            ack_now = 1'b1; // [R07]
            phase_next = PH_DATA;
         end
         PH_DATA: begin
            // A full FIFO refuses a byte for a writable register by not acknowledging it
            ack_now = fifo_in_ready || !rf_writable(ptr_reg); // [R07]
         end
         PH_GC: begin
            ack_now = shift_reg == SWRST_CODE; // [R24]
            phase_next = PH_GC_ARM;
         end
         default: begin
            ack_now = 1'b0; // [R24]
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= ST_IDLE;
         phase_reg <= PH_ADDR;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         mack_reg <= 1'b1;
         sda_oe_o <= 1'b0;
      end else if (start_det) begin
         state_reg <= ST_RX; // [R01]
         phase_reg <= PH_ADDR; // [R24]
         bit_cnt_reg <= 4'h0;
         sda_oe_o <= 1'b0;
      end else if (stop_det || soft_reset_o) begin
         state_reg <= ST_IDLE; // [R01]
         phase_reg <= PH_ADDR;
         sda_oe_o <= 1'b0;
      end else begin
         case (state_reg)
            ST_RX: begin
               if (scl_rise && bit_cnt_reg != BYTE_BITS) begin
                  shift_reg <= {shift_reg[6:0], sda_s}; // [R02] [R04]
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (byte_end) begin
                  bit_cnt_reg <= 4'h0;
                  phase_reg <= ack_now ? phase_next : PH_ADDR;
                  state_reg <= ack_now ? ST_ACK : ST_IDLE;
                  sda_oe_o <= ack_now; // [R03] [R07]
               end
            end
            ST_ACK: begin
               if (scl_fall && phase_reg == PH_READ) begin
                  shift_reg <= rf.rdata;
                  sda_oe_o <= !rf.rdata[7];
                  state_reg <= ST_TX;
               end else if (scl_fall) begin
                  sda_oe_o <= 1'b0; // [R06]
                  state_reg <= ST_RX;
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  bit_cnt_reg <= bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == BYTE_BITS) begin
                  sda_oe_o <= 1'b0; // [R06]
                  bit_cnt_reg <= 4'h0;
                  state_reg <= ST_MACK;
               end else if (scl_fall) begin
                  shift_reg <= {shift_reg[6:0], 1'b0};
                  sda_oe_o <= !shift_reg[6];
               end
            end
            ST_MACK: begin
               if (scl_rise) begin
                  mack_reg <= sda_s;
               end else if (scl_fall && !mack_reg) begin
                  shift_reg <= rf.rdata; // [R08] [R13]
                  sda_oe_o <= !rf.rdata[7];
                  state_reg <= ST_TX;
               end else if (scl_fall) begin
                  state_reg <= ST_IDLE; // [R09]
                  phase_reg <= PH_ADDR;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Open drain: the pin is only ever pulled low
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sda_o <= 1'b0;
      end else begin
         sda_o <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ptr_reg <= PTR_RESET; // [R14]
      end else if (soft_reset_o) begin
         ptr_reg <= PTR_RESET; // [R14]
      end else if (byte_end && phase_reg == PH_CMD) begin
         ptr_reg <= shift_reg; // [R12] [R13]
      end
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         soft_reset_o <= 1'b0;
      end else begin
         soft_reset_o <= stop_det && armed; // [R24]
      end
   end

   assign wr_take = byte_end && phase_reg == PH_DATA && ack_now;
   assign rf.we = wr_take;
   assign rf.waddr = ptr_reg;
   assign rf.wdata = shift_reg;
   assign rf.raddr = ptr_reg; // [R13]
   assign rf.clr = soft_reset_o;

   i2cx_regfile u_regfile (
      .clk_i         (clk_i),
      .resetn_i      (resetn_i),
      .rf            (rf.store),
      .pin_level_i   (pin_sync_reg),
      .event_flags_i (event_flags_i)
   );

   i2cx_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i       (clk_i),
      .resetn_i    (resetn_i),
      .clr_i       (soft_reset_o),
      .in_valid_i  (wr_take && rf_writable(ptr_reg)),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   ({ptr_reg, shift_reg}),
      .out_valid_o (wr_valid_o),
      .out_ready_i (wr_ready_i),
      .out_data_o  (wr_data_o)
   );

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_gc_armed;
      armed ##0 stop_det;
   endsequence
   sequence s_reset_done;
      soft_reset_o ##1 (ptr_reg == PTR_RESET && state_reg == ST_IDLE);
   endsequence

   AST_START_RX: assert property (start_det |=> // [R01]
      state_reg == ST_RX && bit_cnt_reg == 4'h0 && !sda_oe_o)
      else $error("start did not open an address byte");
   AST_STOP_IDLE: assert property (stop_det |=> state_reg == ST_IDLE && !sda_oe_o) // [R01]
      else $error("stop did not return to idle");
   AST_OWN_ACK: assert property ( // [R03]
      byte_end && phase_reg == PH_ADDR && shift_reg[7:1] == {DEV_ADDR_BASE[6:1], strap_reg}
      |=> sda_oe_o && state_reg == ST_ACK)
      else $error("own address not acknowledged");
   AST_FOREIGN_NACK: assert property ( // [R10]
      byte_end && phase_reg == PH_ADDR && shift_reg != GC_ADDR_BYTE &&
      shift_reg[7:1] != {DEV_ADDR_BASE[6:1], strap_reg} |=> !sda_oe_o && state_reg == ST_IDLE)
      else $error("foreign address answered");
   AST_ACK_HOLD: assert property (state_reg == ST_ACK |-> sda_oe_o) // [R07]
      else $error("acknowledge released early");
   AST_SDA_STABLE: assert property (scl_s && scl_prev_reg && !start_det && !stop_det // [R04]
      |=> $stable(sda_oe_o))
      else $error("SDA moved while SCL high");
   AST_WRITE_ACK: assert property ( // [R07]
      byte_end && phase_reg == PH_DATA && fifo_in_ready |=> sda_oe_o ##1 sda_oe_o)
      else $error("written byte not acknowledged");
   AST_PTR_LOAD: assert property (byte_end && phase_reg == PH_CMD // [R12]
      |=> ptr_reg == $past(shift_reg))
      else $error("command byte not stored");
   AST_PTR_KEEP: assert property (!(byte_end && phase_reg == PH_CMD) && !soft_reset_o // [R13]
      |=> $stable(ptr_reg))
      else $error("pointer changed without a command");
   AST_NACK_RELEASE: assert property (state_reg == ST_MACK && scl_fall && mack_reg // [R09]
      && !start_det && !stop_det |=> state_reg == ST_IDLE && !sda_oe_o)
      else $error("SDA not released after read not-acknowledge");
   AST_BYTE_LEN: assert property (bit_cnt_reg <= BYTE_BITS) // [R05]
      else $error("bit count ran past a byte");
   AST_SWRST: assert property (s_gc_armed |=> s_reset_done) // [R24]
      else $error("software reset sequence not honoured");
   AST_GC_EXTRA_NACK: assert property (byte_end && phase_reg == PH_GC_ARM // [R24]
      |=> !sda_oe_o && state_reg == ST_IDLE)
      else $error("extra general call byte answered");
endmodule : i2cx_top
